/* verification/isc_irq_summary_properties.sv */
`timescale 1ns/1ps
module isc_irq_summary_props (
	input logic clk_i,
	input logic rst_i,
	input logic [5:0] external_irq_i,
	input logic data_machine_check_i,
	input logic summary_rd_i,
	input logic clear_wr_i,
	input logic [63:0] clear_wdata_i,
	input logic icache_fill_bc_hit_i,
	input logic [63:0] pending_irq_summary_o,
	input logic data_machine_check_pending_o,
	input logic force_bad_fill_parity_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire arm = clear_wr_i && clear_wdata_i[26];
	a_rsvd_read_zero: assert property (pending_irq_summary_o[63:39] == 25'h0 &&
		pending_irq_summary_o[13:11] == 3'h0 && pending_irq_summary_o[8:5] == 4'h0 &&
		pending_irq_summary_o[2:0] == 3'h0) else $error("reserved summary bit set");
	a_read_data_holds: assert property (!summary_rd_i |=> $stable(pending_irq_summary_o))
		else $error("summary changed without read");
	a_ext_collide_zero: assert property (summary_rd_i && (external_irq_i & ~$past(external_irq_i))
		!= 6'h0 |=> pending_irq_summary_o == 64'h0) else $error("collided read not zero");
	a_arm_sets: assert property (arm |=> force_bad_fill_parity_o) else $error("arm lost");
	a_fill_disarms: assert property (force_bad_fill_parity_o && icache_fill_bc_hit_i && !arm
		|=> !force_bad_fill_parity_o) else $error("fill did not disarm");
	a_armed_holds: assert property (force_bad_fill_parity_o && !icache_fill_bc_hit_i
		|=> force_bad_fill_parity_o) else $error("armed flag dropped");
	a_mchk_latch_sets: assert property (data_machine_check_i |=> data_machine_check_pending_o)
		else $error("check request not latched");
	a_mchk_clear_works: assert property (clear_wr_i && clear_wdata_i[28] && !data_machine_check_i
		|=> !data_machine_check_pending_o) else $error("check request not cleared");
endmodule
bind isc_irq_summary isc_irq_summary_props chk_u (.*);

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
	reg clk_i = 0, rst_i = 1, serial_line_irq_i = 0, corrected_read_err_irq_i = 0;
	reg data_machine_check_i = 0, serial_line_enable_i = 0, corrected_read_enable_i = 0;
	reg async_trap_global_enable_i = 0, native_return_i = 0, summary_rd_i = 0;
	reg clear_wr_i = 0, icache_fill_bc_hit_i = 0;
	reg [1:0] perf_counter_irq_i = 0, perf_counter_enable_i = 0, current_mode_i = 0;
	reg [5:0] external_irq_i = 0, ext_irq_enable_i = 0;
	reg [15:1] sw_irq_request_i = 0, sw_irq_enable_i = 0;
	reg [3:0] async_trap_enable_per_mode_i = 0, async_trap_request_per_mode_i = 0;
	reg [63:0] clear_wdata_i = 0;
	wire [63:0] pending_irq_summary_o;
	wire external_irq_pending_o, data_machine_check_pending_o, force_bad_fill_parity_o, resignal_o;
	integer failures = 0, checks = 0;
	isc_irq_summary uut (.*);
	initial forever #2.5 clk_i = ~clk_i;
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task rd(input logic [63:0] e);
		@(posedge clk_i) summary_rd_i <= 1'h1;
		@(posedge clk_i) summary_rd_i <= 1'h0;
		#1 chk("summary", pending_irq_summary_o, e);
	endtask
	task wr(input logic [63:0] d);
		@(posedge clk_i) {clear_wr_i, clear_wdata_i} <= {1'h1, d};
		@(posedge clk_i) clear_wr_i <= 1'h0;
	endtask
	task t_fields;
		@(posedge clk_i) begin
			{ext_irq_enable_i, serial_line_enable_i, corrected_read_enable_i} <= 8'hff;
			{perf_counter_enable_i, sw_irq_enable_i, async_trap_global_enable_i} <= 18'h3ffff;
			{external_irq_i, serial_line_irq_i, corrected_read_err_irq_i} <= 8'hff;
			{perf_counter_irq_i, sw_irq_request_i, current_mode_i} <= 19'h7ffff;
			{async_trap_enable_per_mode_i, async_trap_request_per_mode_i} <= 8'hff;
		end
		repeat (2) @(posedge clk_i);
		rd(64'h0000007fffffc618);
		@(posedge clk_i) current_mode_i <= 2'h0;
		rd(64'h0000007fffffc008);
		$display("fields done");
	endtask
	task t_clear;
		@(posedge clk_i) {serial_line_irq_i, corrected_read_err_irq_i, perf_counter_irq_i} <= 4'h0;
		wr(64'h0000000120000000);
		rd(64'h0000007edfffc008);
		wr(64'hfffffffe03ffffff);
		rd(64'h0000007edfffc008);
		wr(64'h00000000c0000000);
		rd(64'h0000007e1fffc008);
		@(posedge clk_i) data_machine_check_i <= 1'h1;
		@(posedge clk_i) data_machine_check_i <= 1'h0;
		#1 chk("mchk", data_machine_check_pending_o, 64'h1);
		wr(64'h0000000010000000);
		#1 chk("mchk", data_machine_check_pending_o, 64'h0);
		$display("clear done");
	endtask
	task t_collide;
		@(posedge clk_i) external_irq_i <= 6'h0;
		repeat (2) @(posedge clk_i);
		{summary_rd_i, external_irq_i} <= {1'h1, 6'h3f};
		@(posedge clk_i) summary_rd_i <= 1'h0;
		#1 chk("summary", pending_irq_summary_o, 64'h0);
		rd(64'h0000007e1fffc008);
		@(posedge clk_i) native_return_i <= 1'h1;
		#1 chk("resignal", resignal_o, 64'h1);
		chk("pending", external_irq_pending_o, 64'h1);
		@(posedge clk_i) native_return_i <= 1'h0;
		$display("collide done");
	endtask
	task t_parity;
		wr(64'h0000000004000000);
		#1 chk("armed", force_bad_fill_parity_o, 64'h1);
		@(posedge clk_i) icache_fill_bc_hit_i <= 1'h1;
		@(posedge clk_i) icache_fill_bc_hit_i <= 1'h0;
		#1 chk("armed", force_bad_fill_parity_o, 64'h0);
		$display("parity done");
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		t_fields;
		t_clear;
		t_collide;
		t_parity;
		give_verdict;
	end
	initial begin
		#5000;
		failures++;
		give_verdict;
	end
endmodule

/* verilog/isc_edge_latch.v */
`timescale 1ns/1ps
`include "isc_regs.vh"

// ------------------------------------------------------------
// Sticky per-bit latch, set wins over clear
// ------------------------------------------------------------
module isc_edge_latch #(
	parameter W = 5
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] set_i,
	input wire [W-1:0] clr_i,
	output wire [W-1:0] q_o,
	output wire [W-1:0] new_o
);
	reg [W-1:0] q_reg;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					q_reg[i] <= 1'b0;
				end else if (set_i[i]) begin
					q_reg[i] <= 1'b1;
				end else if (clr_i[i]) begin
					q_reg[i] <= 1'b0;
				end
			end
			// Rising request not yet latched
			assign new_o[i] = set_i[i] & ~q_reg[i];
		end
	endgenerate
	assign q_o = q_reg;
endmodule

/* verilog/isc_irq_summary.v */
`timescale 1ns/1ps
`include "isc_regs.vh"

// Function
// - The summary register is read-only and shows each request only while pending and enabled.
// - A read that coincides with a new hardware, serial, corrected-read or counter request returns zero.
// - A request lost to such a read stays pending and is signalled again on return to native mode.
// - External at 38:33, serial at 32, corrected read at 31, software 15:1 at 28:14.
// - Counter 0 pending at bit 29, counter 1 pending at bit 30.
// - Trap pending bits: user 10, supervisor 9, executive 4, kernel 3.
// - A mode's trap bit needs its enable, its request and current mode at or above that mode.
// - Reserved bits 63:39, 13:11, 8:5 and 2:0 read as zero.
// - The clear register is write-only and only clears edge requests and sets one test control.
// - Writing one to bit 32 or 31 clears the serial or corrected-read request; zero leaves it.
// - Writing one to bit 30 or 29 clears only the matching counter request.
// - Writing one to bit 28 clears the data machine check request.
// - Writing one to bit 26 arms a one-shot forcing bad parity on the next board-cache icache fill.
// - Summary bits are gated by the matching enable fields.
module isc_irq_summary (
	input wire clk_i,
	input wire rst_i,
	input wire [5:0] external_irq_i,
	input wire serial_line_irq_i,
	input wire corrected_read_err_irq_i,
	input wire [1:0] perf_counter_irq_i,
	input wire data_machine_check_i,
	input wire [15:1] sw_irq_request_i,
	input wire [5:0] ext_irq_enable_i,
	input wire serial_line_enable_i,
	input wire corrected_read_enable_i,
	input wire [1:0] perf_counter_enable_i,
	input wire [15:1] sw_irq_enable_i,
	input wire async_trap_global_enable_i,
	input wire [3:0] async_trap_enable_per_mode_i,
	input wire [3:0] async_trap_request_per_mode_i,
	input wire [1:0] current_mode_i,
	input wire native_return_i,
	input wire summary_rd_i,
	input wire clear_wr_i,
	input wire [63:0] clear_wdata_i,
	input wire icache_fill_bc_hit_i,
	output reg [63:0] pending_irq_summary_o,
	output wire external_irq_pending_o,
	output wire data_machine_check_pending_o,
	output wire force_bad_fill_parity_o,
	output wire resignal_o
);
	// ------------------------------------------------------------
	// Edge-sensitive request latches
	// ------------------------------------------------------------
	wire [4:0] edge_set;
	wire [4:0] edge_clr;
	wire [4:0] edge_q;
	wire [4:0] edge_new;
	wire [63:0] summary_next;
	wire [3:0] ast_pend;
	wire new_irq;
	reg [5:0] ext_prev_reg;
	reg lost_reg;
	reg fbp_reg;

	wire clr_sl;
	wire clr_cr;
	wire clr_pc1;
	wire clr_pc0;
	wire clr_mchk;

	assign edge_set[4] = data_machine_check_i;
	assign edge_set[3] = serial_line_irq_i;
	assign edge_set[2] = corrected_read_err_irq_i;
	assign edge_set[1:0] = perf_counter_irq_i;

	// ------------------------------------------------------------
	// Clear register decode, write-one fields only
	// ------------------------------------------------------------
	assign clr_sl = clear_wr_i & clear_wdata_i[`ISC_SL_BIT];
	assign clr_cr = clear_wr_i & clear_wdata_i[`ISC_CR_BIT];
	assign clr_pc1 = clear_wr_i & clear_wdata_i[`ISC_PC1_BIT];
	assign clr_pc0 = clear_wr_i & clear_wdata_i[`ISC_PC0_BIT];
	assign clr_mchk = clear_wr_i & clear_wdata_i[`ISC_CLR_MCHK_BIT];
	assign edge_clr = {clr_mchk, clr_sl, clr_cr, clr_pc1, clr_pc0};

	isc_edge_latch #(
		.W(5)
	) u_latch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(edge_set),
		.clr_i(edge_clr),
		.q_o(edge_q),
		.new_o(edge_new)
	);

	assign data_machine_check_pending_o = edge_q[4];

	// ------------------------------------------------------------
	// Trap pending per mode
	// ------------------------------------------------------------
	wire [3:0] trap_armed;

	assign trap_armed = {4{async_trap_global_enable_i}} & async_trap_enable_per_mode_i &
		async_trap_request_per_mode_i;

	genvar m;
	generate
		for (m = 0; m < 4; m = m + 1) begin : g_ast
			localparam [31:0] MODE_IDX = m;
			wire mode_reached;
			assign mode_reached = (current_mode_i >= MODE_IDX[1:0]);
			assign ast_pend[m] = trap_armed[m] & mode_reached;
		end
	endgenerate

	// ------------------------------------------------------------
	// Enabled summary fields
	// ------------------------------------------------------------
	wire [5:0] ext_field;
	wire sl_field;
	wire cr_field;
	wire [1:0] pc_field;
	wire [14:0] sw_field;
	wire [1:0] ast_hi_field;
	wire [1:0] ast_lo_field;

	assign ext_field = external_irq_i & ext_irq_enable_i;
	assign sl_field = edge_q[3] & serial_line_enable_i;
	assign cr_field = edge_q[2] & corrected_read_enable_i;
	assign pc_field = edge_q[1:0] & perf_counter_enable_i;
	assign sw_field = sw_irq_request_i & sw_irq_enable_i;
	assign ast_hi_field = {ast_pend[`ISC_MODE_USER], ast_pend[`ISC_MODE_SUPER]};
	assign ast_lo_field = {ast_pend[`ISC_MODE_EXEC], ast_pend[`ISC_MODE_KERNEL]};

	assign summary_next = {25'h0000000, ext_field, sl_field, cr_field, pc_field, sw_field,
		3'h0, ast_hi_field, 4'h0, ast_lo_field, 3'h0};

	// ------------------------------------------------------------
	// New request detection
	// ------------------------------------------------------------
	wire [5:0] ext_rise;
	wire [3:0] edge_rise;
	wire read_collide;

	assign ext_rise = external_irq_i & ~ext_prev_reg;
	// Machine check latch is not a colliding source
	assign edge_rise = edge_new[3:0];
	assign new_irq = (|ext_rise) | (|edge_rise);
	assign read_collide = summary_rd_i & new_irq;
	assign external_irq_pending_o = |summary_next;

	// ------------------------------------------------------------
	// Read data register
	// ------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pending_irq_summary_o <= `ISC_ZERO64;
		end else if (read_collide) begin
			pending_irq_summary_o <= `ISC_ZERO64;
		end else if (summary_rd_i) begin
			pending_irq_summary_o <= summary_next;
		end
	end

	// ------------------------------------------------------------
	// External request history for rise detection
	// ------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_prev_reg <= 6'h00;
		end else begin
			ext_prev_reg <= external_irq_i;
		end
	end

	// ------------------------------------------------------------
	// Lost request flag, collision wins over native return
	// ------------------------------------------------------------
	reg lost_next;
	always @* begin
		lost_next = lost_reg;
		if (read_collide) begin
			lost_next = 1'b1;
		end else if (native_return_i) begin
			lost_next = 1'b0;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lost_reg <= 1'b0;
		end else begin
			lost_reg <= lost_next;
		end
	end

	// ------------------------------------------------------------
	// One-shot bad fill parity control, arm wins over fill
	// ------------------------------------------------------------
	wire arm_req;
	reg fbp_next;
	assign arm_req = clear_wr_i & clear_wdata_i[`ISC_CLR_FBP_BIT];
	always @* begin
		fbp_next = fbp_reg;
		if (arm_req) begin
			fbp_next = 1'b1;
		end else if (icache_fill_bc_hit_i) begin
			fbp_next = 1'b0;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fbp_reg <= 1'b0;
		end else begin
			fbp_reg <= fbp_next;
		end
	end

	// ------------------------------------------------------------
	// Re-signal on native return; latches still hold the request
	// ------------------------------------------------------------
	assign resignal_o = lost_reg & native_return_i & external_irq_pending_o;
	assign force_bad_fill_parity_o = fbp_reg;
endmodule

/* verilog/isc_regs.vh */
`ifndef ISC_REGS_VH
`define ISC_REGS_VH

// ------------------------------------------------------------
// Summary register fields
// ------------------------------------------------------------
`define ISC_EXT_HI 38
`define ISC_EXT_LO 33
`define ISC_SL_BIT 32
`define ISC_CR_BIT 31
`define ISC_PC1_BIT 30
`define ISC_PC0_BIT 29
`define ISC_SW_HI 28
`define ISC_SW_LO 14
`define ISC_AST_U_BIT 10
`define ISC_AST_S_BIT 9
`define ISC_AST_E_BIT 4
`define ISC_AST_K_BIT 3

// ------------------------------------------------------------
// Clear register fields
// ------------------------------------------------------------
`define ISC_CLR_MCHK_BIT 28
`define ISC_CLR_FBP_BIT 26

// ------------------------------------------------------------
// Mode codes and reset values
// ------------------------------------------------------------
`define ISC_MODE_KERNEL 2'h0
`define ISC_MODE_EXEC 2'h1
`define ISC_MODE_SUPER 2'h2
`define ISC_MODE_USER 2'h3
`define ISC_ZERO64 64'h0000000000000000

`endif
